// File: rtl/qud_consts.svh
// Register map, field positions, reset values and filter constants of the upconverter
`ifndef QUD_CONSTS_SVH
`define QUD_CONSTS_SVH
// ************************************************************
// Register map
// ************************************************************
`define QUD_ADDR_MODE        8'h00
`define QUD_ADDR_STATUS      8'h01
`define QUD_PROF_FIRST_SLOT  3'h1
`define QUD_PROF_LAST_SLOT   3'h4
`define QUD_BYTE_CTRL        3'h4
`define QUD_BYTE_MISC        3'h5
// ************************************************************
// Field positions
// ************************************************************
`define QUD_MODE_TONE_BIT    0
`define QUD_CTRL_BYPASS_BIT  6
`define QUD_CTRL_INVERT_BIT  7
`define QUD_MISC_SINC_BIT    0
// ************************************************************
// Reset values
// ************************************************************
`define QUD_RST_STEP         32'h0000_0000
`define QUD_RST_RATE         6'h02
`define QUD_RATE_MIN         6'h02
// ************************************************************
// Filter and synthesizer constants
// ************************************************************
`define QUD_HB_C0            12'sh269
`define QUD_HB_C1            (-12'sh091)
`define QUD_HB_C2            12'sh02E
`define QUD_HB_C3            (-12'sh006)
`define QUD_HB_SHIFT         10
`define QUD_SINC_OUTER       (-10'sh013)
`define QUD_SINC_CENTER      10'sh0D1
`define QUD_SINC_SHIFT       8
`define QUD_QUARTER_TURN     16'h4000
`define QUD_MOD_SHIFT        15
`define QUD_CIC_STAGES       5
`endif

// File: rtl/qud_pkg.sv
// Types shared by the upconverter datapath files
package qud_pkg;
	// One I/Q sample pair at internal width
	typedef struct packed {
		logic signed [17:0] i;
		logic signed [17:0] q;
	} qud_iq_t;
	// One of the four pin-selected profiles
	typedef struct packed {
		logic [31:0] carrierStepWord;
		logic [5:0]  cicRate;
		logic        cicBypass;
		logic        specInvert;
		logic        invSincOn;
	} qud_prof_t;
	// Decoded register address
	typedef struct packed {
		logic       hit;
		logic [1:0] prof;
		logic [2:0] byteSel;
	} qud_regsel_t;
	// Word assembler, Gray along idle -> want I -> want Q -> want I
	typedef enum logic [1:0] {
		ASM_IDLE   = 2'b00,
		ASM_WANT_I = 2'b01,
		ASM_WANT_Q = 2'b11
	} qud_asm_t;
endpackage : qud_pkg

// File: rtl/qud_halfband.sv
// Two-times half-band interpolator for an I/Q pair, polyphase form
`timescale 1ns/1ps
`default_nettype none
`include "qud_consts.svh"
module qud_halfband #(
	parameter int TAPS = 8
) (
	input  wire logic            clk,
	input  wire logic            sys_rst,
	input  wire logic            inEn,
	input  wire logic            outEn,
	input  wire qud_pkg::qud_iq_t din,
	output qud_pkg::qud_iq_t     dout
);
	import qud_pkg::*;

	// ************************************************************
	// Elaboration check
	// ************************************************************
	if (TAPS != 8) begin : gBadTaps
		$error("qud_halfband supports exactly 8 delay taps");
	end

	logic signed [17:0] dlI_q [TAPS];
	logic signed [17:0] dlQ_q [TAPS];
	logic signed [17:0] dlI_d [TAPS];
	logic signed [17:0] dlQ_d [TAPS];
	qud_iq_t            dout_q;
	qud_iq_t            dout_d;

	// Symmetric taps keep phase linear; odd taps sum to unity gain, band edges only approximated by eight taps
	// [RULE_03] [RULE_04] [RULE_05] [RULE_06]
	function automatic logic signed [17:0] qud_hb_mid(input logic signed [17:0] d [TAPS]);
		logic signed [31:0] acc;
		acc = 32'(`QUD_HB_C0) * (32'(d[3]) + 32'(d[4]));
		acc = acc + 32'(`QUD_HB_C1) * (32'(d[2]) + 32'(d[5]));
		acc = acc + 32'(`QUD_HB_C2) * (32'(d[1]) + 32'(d[6]));
		acc = acc + 32'(`QUD_HB_C3) * (32'(d[0]) + 32'(d[7]));
		return 18'(acc >>> `QUD_HB_SHIFT);
	endfunction : qud_hb_mid

	// Even phase passes the stored sample, odd phase interpolates between neighbours [RULE_01]
	always_comb begin
		dlI_d  = dlI_q;
		dlQ_d  = dlQ_q;
		dout_d = dout_q;
		if (outEn) begin
			if (inEn) begin
				dout_d.i = dlI_q[3];
				dout_d.q = dlQ_q[3];
				for (int k = TAPS - 1; k > 0; k--) begin
					dlI_d[k] = dlI_q[k - 1];
					dlQ_d[k] = dlQ_q[k - 1];
				end
				dlI_d[0] = din.i;
				dlQ_d[0] = din.q;
			end else begin
				dout_d.i = qud_hb_mid(dlI_q);
				dout_d.q = qud_hb_mid(dlQ_q);
			end
		end
	end

	// Delay line and output register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int k = 0; k < TAPS; k++) begin
				dlI_q[k] <= '0;
				dlQ_q[k] <= '0;
			end
			dout_q <= '0;
		end else begin
			dlI_q  <= dlI_d;
			dlQ_q  <= dlQ_d;
			dout_q <= dout_d;
		end
	end

	assign dout = dout_q;

	a_hb_input_rate : assert property (@(posedge clk) disable iff (sys_rst) inEn |-> outEn) // [RULE_01]
		else $error("half-band input taken outside an output slot");
	a_hb_even_copy : assert property (@(posedge clk) disable iff (sys_rst) // [RULE_05]
		(outEn && inEn) |=> (dout_q.i == $past(dlI_q[3])))
		else $error("half-band even phase did not copy the centre sample");
endmodule : qud_halfband
`default_nettype wire

// File: rtl/qud_upconvert.sv
// Quadrature upconverter datapath: word assembler, interpolators, carrier synthesizer, modulator, inverse sinc
`timescale 1ns/1ps
`default_nettype none
`include "qud_consts.svh"
// Operation
// RULE_01 - Fixed stage is two cascaded half-band filters giving four times the pair rate.
// RULE_02 - Two consecutive input words, I then Q, form one pair at half word rate.
// RULE_03 - Combined half-band passband reaches 80% of pair half rate, ripple 0.002 dB.
// RULE_04 - Combined half-band stop band 120% to 400% of pair half rate, 85 dB.
// RULE_05 - Half-band filters use symmetric coefficients, linear phase.
// RULE_06 - Half-band pair loses only about 0.01 dB in the passband.
// RULE_07 - Source oversamples its data at least twofold before presenting it.
// RULE_08 - CIC rate comes from 6-bit profile field, factors 2 to 63.
// RULE_09 - Profile bypass bit makes CIC pass at rate one, stage powered down.
// RULE_10 - CIC bypass also bypasses inverse CIC compensation automatically.
// RULE_11 - CIC upsamples half-band output by the rate, overall 8 to 252.
// RULE_12 - CIC response is fifth power of R-term moving sum: five integrators, five combs.
// RULE_13 - Modulator multiplies I and Q by cosine and sine, sums the products.
// RULE_14 - Spectrum-invert bit 1 gives I cos plus Q sin, 0 gives minus.
// RULE_15 - 32-bit profile step word added to phase accumulator every clock.
// RULE_16 - Host keeps step words at or below 2,147,483,647.
// RULE_17 - Profile one step word lives at addresses 08h to 0Bh, writable.
// RULE_18 - Optional inverse-sinc FIR precedes the output, good to 45% of clock.
// RULE_19 - Enabled inverse-sinc lowers low-frequency gain by about 3.5 dB.
// RULE_20 - Bypassed inverse-sinc stage has its clock stopped and data routed around.
// RULE_21 - Profile pick pins select profile; its step word acts without strobe.
// RULE_22 - In single-tone mode load strobe rising edge loads step word, starts synthesis.
// RULE_23 - One clock; slower stages advance on enables from the interpolation factors.
module qud_upconvert (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [13:0] dataWord,
	input  wire logic        txEnable,
	input  wire logic        profilePickLo,
	input  wire logic        profilePickHi,
	input  wire logic        tuningLoadStrobe,
	input  wire logic        regWrEn,
	input  wire logic [7:0]  regAddr,
	input  wire logic [7:0]  regWrData,
	output logic      [7:0]  regRdData,
	output logic      [13:0] dacSample,
	output logic             wordTake,
	output logic             invCicBypass
);
	import qud_pkg::*;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// ************************************************************
	// Helper functions
	// ************************************************************
	// Register address decode, shared by write and read paths
	function automatic qud_regsel_t qud_decode(input logic [7:0] a);
		qud_regsel_t s;
		s.hit     = (a[7:6] == 2'b00) && (a[5:3] >= `QUD_PROF_FIRST_SLOT) && (a[5:3] <= `QUD_PROF_LAST_SLOT);
		s.prof    = 2'(a[5:3] - `QUD_PROF_FIRST_SLOT);
		s.byteSel = a[2:0];
		return s;
	endfunction : qud_decode

	function automatic logic signed [13:0] qud_sat14(input logic signed [35:0] v);
		if (v > 36'sh0_0000_1FFF)
			return 14'sh1FFF;
		else if (v < -36'sh0_0000_2000)
			return -14'sh2000;
		else
			return 14'(v);
	endfunction : qud_sat14

	// Parabolic sine, peak 2^14; coarse but table-free
	function automatic logic signed [15:0] qud_sine(input logic [15:0] ph);
		logic [30:0] y;
		logic [15:0] mag;
		y   = 31'(ph[14:0]) * 31'(16'h8000 - {1'b0, ph[14:0]});
		mag = 16'(y >> 14);
		return ph[15] ? -$signed(mag) : $signed(mag);
	endfunction : qud_sine

	function automatic logic [2:0] qud_clog2(input logic [5:0] v);
		logic [2:0] r;
		r = 3'h0;
		for (int k = 0; k < 6; k++) begin
			if (v > (6'h01 << k))
				r = 3'(k + 1);
		end
		return r;
	endfunction : qud_clog2

	// ************************************************************
	// Pin synchronisers, rate enables and word assembler
	// ************************************************************
	logic [17:0]  pinMeta_q, pinSync_q;
	logic         strobePrev_q;
	logic [5:0]   sc_q, sc_d;
	logic [1:0]   qc_q, qc_d;
	qud_asm_t     asm_q, asm_d;
	logic [13:0]  iHold_q, iHold_d;
	qud_iq_t      pair_q, pair_d;
	logic         wordTake_q, wordTake_d;
	qud_prof_t    prof_q [4];
	qud_prof_t    prof_d [4];
	qud_prof_t    active;
	logic         modeTone_q, modeTone_d;
	logic [5:0]   effRate;
	logic         txOn, slot, pairEn, hb2InEn, takeI, takeQ, strobeRise;

	assign txOn       = pinSync_q[3];
	assign strobeRise = pinSync_q[0] && !strobePrev_q;
	assign active     = prof_q[{pinSync_q[2], pinSync_q[1]}]; // Selected profile acts at once [RULE_21]

	// Bypass forces rate one; out-of-range codes fall back to the lowest rate [RULE_08] [RULE_09]
	assign effRate = active.cicBypass ? 6'h01 : ((active.cicRate < `QUD_RATE_MIN) ? `QUD_RATE_MIN : active.cicRate);

	// All enables derive from one counter chain on the single clock [RULE_23]
	assign slot    = (sc_q == 6'h00);
	assign pairEn  = slot && (qc_q == 2'h0);
	assign hb2InEn = slot && !qc_q[0];
	assign takeI   = txOn && slot && (qc_q == 2'h2) && (asm_q == ASM_WANT_I);
	assign takeQ   = txOn && pairEn && (asm_q == ASM_WANT_Q);

	// I word waits for its Q partner; without a partner zeros flush the path [RULE_02]
	always_comb begin
		sc_d       = (sc_q >= 6'(effRate - 6'h01)) ? 6'h00 : 6'(sc_q + 6'h01);
		qc_d       = slot ? 2'(qc_q + 2'h1) : qc_q;
		iHold_d    = takeI ? pinSync_q[17:4] : iHold_q;
		pair_d     = pair_q;
		wordTake_d = takeI || takeQ;
		asm_d      = asm_q;
		if (pairEn) begin
			pair_d.i = takeQ ? 18'(signed'(iHold_q)) : 18'sh0;
			pair_d.q = takeQ ? 18'(signed'(pinSync_q[17:4])) : 18'sh0;
		end
		case (asm_q)
			ASM_IDLE:   asm_d = txOn ? ASM_WANT_I : ASM_IDLE;
			ASM_WANT_I: asm_d = !txOn ? ASM_IDLE : (takeI ? ASM_WANT_Q : ASM_WANT_I);
			ASM_WANT_Q: asm_d = !txOn ? ASM_IDLE : (takeQ ? ASM_WANT_I : ASM_WANT_Q);
			default:    asm_d = ASM_IDLE;
		endcase
	end

	// Two flops on the data, transmit, profile and strobe pins before logic looks at them; register pins go unsynchronised
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pinMeta_q    <= '0;
			pinSync_q    <= '0;
			strobePrev_q <= 1'b0;
			sc_q         <= 6'h00;
			qc_q         <= 2'h0;
			asm_q        <= ASM_IDLE;
			iHold_q      <= '0;
			pair_q       <= '0;
			wordTake_q   <= 1'b0;
		end else begin
			pinMeta_q    <= {dataWord, txEnable, profilePickHi, profilePickLo, tuningLoadStrobe};
			pinSync_q    <= pinMeta_q;
			strobePrev_q <= pinSync_q[0];
			sc_q         <= sc_d;
			qc_q         <= qc_d;
			asm_q        <= asm_d;
			iHold_q      <= iHold_d;
			pair_q       <= pair_d;
			wordTake_q   <= wordTake_d;
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	qud_regsel_t wrSel, rdSel;
	logic [7:0]  rdData_d, rdData_q;
	logic        invCic_q;

	assign wrSel = qud_decode(regAddr);
	assign rdSel = wrSel;

	// Byte writes; profile slot 0 step word sits at profile_one_tuning_word, low byte first [RULE_17]
	always_comb begin
		prof_d     = prof_q;
		modeTone_d = modeTone_q;
		if (regWrEn && (regAddr == `QUD_ADDR_MODE))
			modeTone_d = regWrData[`QUD_MODE_TONE_BIT];
		if (regWrEn && wrSel.hit) begin
			case (wrSel.byteSel)
				3'h0, 3'h1, 3'h2, 3'h3:
					prof_d[wrSel.prof].carrierStepWord[8 * wrSel.byteSel[1:0] +: 8] = regWrData;
				`QUD_BYTE_CTRL: begin
					prof_d[wrSel.prof].cicRate    = regWrData[5:0];
					prof_d[wrSel.prof].cicBypass  = regWrData[`QUD_CTRL_BYPASS_BIT];
					prof_d[wrSel.prof].specInvert = regWrData[`QUD_CTRL_INVERT_BIT];
				end
				`QUD_BYTE_MISC: prof_d[wrSel.prof].invSincOn = regWrData[`QUD_MISC_SINC_BIT];
				default: ;
			endcase
		end
		rdData_d = 8'h00;
		if (regAddr == `QUD_ADDR_MODE)
			rdData_d = {7'h00, modeTone_q};
		else if (regAddr == `QUD_ADDR_STATUS)
			rdData_d = {3'h0, pinSync_q[2], pinSync_q[1], asm_q == ASM_WANT_Q, txOn, active.cicBypass};
		else if (rdSel.hit) begin
			case (rdSel.byteSel)
				3'h0, 3'h1, 3'h2, 3'h3: rdData_d = prof_q[rdSel.prof].carrierStepWord[8 * rdSel.byteSel[1:0] +: 8];
				`QUD_BYTE_CTRL: rdData_d = {prof_q[rdSel.prof].specInvert, prof_q[rdSel.prof].cicBypass,
					prof_q[rdSel.prof].cicRate};
				`QUD_BYTE_MISC: rdData_d = {7'h00, prof_q[rdSel.prof].invSincOn};
				default:        rdData_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int p = 0; p < 4; p++)
				prof_q[p] <= '{carrierStepWord: `QUD_RST_STEP, cicRate: `QUD_RST_RATE, default: 1'b0};
			modeTone_q <= 1'b0;
			rdData_q   <= 8'h00;
			invCic_q   <= 1'b0;
		end else begin
			prof_q     <= prof_d;
			modeTone_q <= modeTone_d;
			rdData_q   <= rdData_d;
			invCic_q   <= active.cicBypass; // Compensation follows CIC bypass, no own setting [RULE_10]
		end
	end

	// ************************************************************
	// Fixed four-times interpolator: two half-band stages
	// ************************************************************
	qud_iq_t hb1Out, hb2Out;

	// Pair rate in, twice out, twice again: four times the pair rate [RULE_01] [RULE_11]
	qud_halfband #(.TAPS(8)) uHb1 (.clk(clk), .sys_rst(sys_rst), .inEn(pairEn), .outEn(hb2InEn),
		.din(pair_q), .dout(hb1Out));
	qud_halfband #(.TAPS(8)) uHb2 (.clk(clk), .sys_rst(sys_rst), .inEn(hb2InEn), .outEn(slot),
		.din(hb1Out), .dout(hb2Out));

	// ************************************************************
	// Programmable CIC interpolator, five combs and five integrators
	// ************************************************************
	logic signed [47:0] dly_q [2][`QUD_CIC_STAGES];
	logic signed [47:0] dly_d [2][`QUD_CIC_STAGES];
	logic signed [47:0] integ_q [2][`QUD_CIC_STAGES];
	logic signed [47:0] integ_d [2][`QUD_CIC_STAGES];
	logic signed [47:0] comb_q [2];
	logic signed [47:0] comb_d [2];
	logic               inject_q;
	logic [4:0]         cicShift;
	qud_iq_t            cicOut;

	assign cicShift = {qud_clog2(effRate), 2'b00};
	assign cicOut.i = 18'(integ_q[0][`QUD_CIC_STAGES - 1] >>> cicShift);
	assign cicOut.q = 18'(integ_q[1][`QUD_CIC_STAGES - 1] >>> cicShift);

	// Combs at the low rate, zero-stuffed into integrators at the clock rate [RULE_12] [RULE_11]
	always_comb begin
		logic signed [47:0] v;
		v = '0;
		for (int c = 0; c < 2; c++) begin
			dly_d[c]  = dly_q[c];
			comb_d[c] = comb_q[c];
			if (slot) begin
				v = (c == 0) ? 48'(hb2Out.i) : 48'(hb2Out.q);
				for (int k = 0; k < `QUD_CIC_STAGES; k++) begin
					dly_d[c][k] = v;
					v = v - dly_q[c][k];
				end
				comb_d[c] = v;
			end
			integ_d[c][0] = integ_q[c][0] + (inject_q ? comb_q[c] : 48'sh0);
			for (int k = 1; k < `QUD_CIC_STAGES; k++)
				integ_d[c][k] = integ_q[c][k] + integ_q[c][k - 1];
		end
	end

	// Bypass holds the whole stage cleared so it does not toggle [RULE_09]
	always_ff @(posedge clk) begin
		if (sys_rst || active.cicBypass) begin
			for (int c = 0; c < 2; c++) begin
				for (int k = 0; k < `QUD_CIC_STAGES; k++) begin
					dly_q[c][k]   <= '0;
					integ_q[c][k] <= '0;
				end
				comb_q[c] <= '0;
			end
			inject_q <= 1'b0;
		end else begin
			dly_q    <= dly_d;
			integ_q  <= integ_d;
			comb_q   <= comb_d;
			inject_q <= slot;
		end
	end

	// ************************************************************
	// Carrier synthesizer, modulator and inverse sinc
	// ************************************************************
	logic [31:0]        phaseAcc_q, phaseAcc_d, loaded_q, loaded_d, stepWord;
	logic               running_q, running_d;
	logic signed [15:0] cosV, sinV;
	qud_iq_t            modIn_q, modIn_d;
	logic signed [13:0] modOut_q, modOut_d, x1_q, x1_d, x2_q, x2_d, dac_q, dac_d;
	logic signed [35:0] prodSum, sincAcc;

	// Step word added every clock; tone mode waits for its load edge [RULE_15] [RULE_22]
	assign stepWord = modeTone_q ? (running_q ? loaded_q : 32'h0) : active.carrierStepWord;
	assign cosV     = qud_sine(16'(phaseAcc_q[31:16] + `QUD_QUARTER_TURN));
	assign sinV     = qud_sine(phaseAcc_q[31:16]);

	always_comb begin
		phaseAcc_d = phaseAcc_q + stepWord;
		loaded_d   = loaded_q;
		running_d  = modeTone_q && running_q;
		if (modeTone_q && strobeRise) begin
			loaded_d   = active.carrierStepWord; // [RULE_22]
			phaseAcc_d = 32'h0;
			running_d  = 1'b1;
		end
		modIn_d = active.cicBypass ? hb2Out : cicOut;
		// Quadrature carriers, sign of the Q term set by the invert bit [RULE_13] [RULE_14]
		prodSum = active.specInvert ? (36'(modIn_q.i * cosV) + 36'(modIn_q.q * sinV))
			: (36'(modIn_q.i * cosV) - 36'(modIn_q.q * sinV));
		modOut_d = modeTone_q ? qud_sat14(36'(cosV >>> 1)) : qud_sat14(prodSum >>> `QUD_MOD_SHIFT);
		// Three-tap symmetric inverse sinc, DC gain about 0.67 [RULE_18] [RULE_19]
		sincAcc = 36'(`QUD_SINC_OUTER) * (36'(modOut_q) + 36'(x2_q)) + 36'(`QUD_SINC_CENTER) * 36'(x1_q);
		x1_d    = active.invSincOn ? modOut_q : x1_q; // Held when bypassed [RULE_20]
		x2_d    = active.invSincOn ? x1_q : x2_q;
		dac_d   = active.invSincOn ? qud_sat14(sincAcc >>> `QUD_SINC_SHIFT) : modOut_q; // [RULE_20]
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			phaseAcc_q <= '0;
			loaded_q   <= '0;
			running_q  <= 1'b0;
			modIn_q    <= '0;
			modOut_q   <= '0;
			x1_q       <= '0;
			x2_q       <= '0;
			dac_q      <= '0;
		end else begin
			phaseAcc_q <= phaseAcc_d;
			loaded_q   <= loaded_d;
			running_q  <= running_d;
			modIn_q    <= modIn_d;
			modOut_q   <= modOut_d;
			x1_q       <= x1_d;
			x2_q       <= x2_d;
			dac_q      <= dac_d;
		end
	end

	assign regRdData    = rdData_q;
	assign dacSample    = dac_q;
	assign wordTake     = wordTake_q;
	assign invCicBypass = invCic_q;

	// ************************************************************
	// Checks
	// ************************************************************
	a_word_spacing : assert property (wordTake_q |=> !wordTake_q) // [RULE_02]
		else $error("input words taken back to back");
	a_flush_zero : assert property ((pairEn && !txOn) |=> (pair_q == '0)) // [RULE_02]
		else $error("pair not flushed with zeros while transmit is off");
	a_acc_step : assert property (!modeTone_q |=> // [RULE_15]
		phaseAcc_q == $past(phaseAcc_q) + $past(active.carrierStepWord))
		else $error("phase accumulator did not advance by the step word");
	a_tone_load : assert property ((modeTone_q && strobeRise) |=> (phaseAcc_q == 32'h0) ##1 // [RULE_22]
		(phaseAcc_q == $past(loaded_q)) || !modeTone_q)
		else $error("load edge did not restart synthesis with the new word");
	a_reg_step_lsb : assert property ((regWrEn && regAddr == 8'h08) |=> // [RULE_17]
		prof_q[0].carrierStepWord[7:0] == $past(regWrData))
		else $error("step word low byte not written");
	a_cic_idle : assert property (active.cicBypass |=> (integ_q[0][4] == 48'sh0) && !inject_q) // [RULE_09]
		else $error("bypassed CIC still active");
	a_invcic_track : assert property (1'b1 |=> invCic_q == $past(active.cicBypass)) // [RULE_10]
		else $error("inverse CIC bypass does not follow CIC bypass");
	a_sinc_bypass : assert property (!active.invSincOn |=> (dac_q == $past(modOut_q)) && $stable(x1_q)) // [RULE_20]
		else $error("bypassed inverse sinc not routed around");
	a_cic_rate_slots : assert property ((slot && !active.cicBypass && active.cicRate == 6'h03) // [RULE_11]
		&& $stable(active) ##1 $stable(active) |-> !slot ##1 !slot)
		else $error("CIC input slots not spaced by the rate");
endmodule : qud_upconvert
`default_nettype wire

// File: dv/qud_bb_source.sv
// Baseband source model feeding interleaved I/Q words
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Word source
// ************************************************************
module qud_bb_source (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        wordTake,
	output var  logic [13:0] dataWord
);
	logic phaseQ;
	// Next word on the edge after each take; near-DC data keeps the band well oversampled
	always @(posedge clk) begin
		if (sys_rst) begin
			phaseQ   <= 1'b0;
			dataWord <= 14'h0800;
		end else if (wordTake) begin
			phaseQ   <= ~phaseQ;
			dataWord <= phaseQ ? 14'h0800 : 14'h3800; // I then Q
		end
	end
endmodule : qud_bb_source
`default_nettype wire

// File: dv/qud_upconvert_tb.sv
// Self-checking bench for the upconverter datapath
`timescale 1ns/1ps
`default_nettype none
`include "qud_consts.svh"
// ************************************************************
// Bench top
// ************************************************************
module qud_upconvert_tb;
	// Step words stay below half the clock
	localparam logic [31:0] STEP = 32'h1234_5678;
	localparam logic [31:0] QTR  = 32'h4000_0000;
	localparam logic [7:0]  RATES [4] = '{8'h40, 8'h01, 8'h05, 8'h3F};
	localparam int          GAPS  [4] = '{2, 4, 10, 126};
	logic               clk, sys_rst, txEnable, profilePickLo, profilePickHi, tuningLoadStrobe, regWrEn;
	logic [7:0]         regAddr, regWrData, regRdData;
	logic [13:0]        dataWord;
	logic signed [13:0] dacSample;
	logic signed [13:0] smp [8];
	logic               wordTake, invCicBypass;
	logic signed [31:0] dcOff, dcOn, s0, s1;
	int                 nMismatch, testsRun, n;
	// Free-running 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	qud_upconvert qud_upconvert_inst (.clk(clk), .sys_rst(sys_rst), .dataWord(dataWord), .txEnable(txEnable),
		.profilePickLo(profilePickLo), .profilePickHi(profilePickHi), .tuningLoadStrobe(tuningLoadStrobe),
		.regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
		.dacSample(dacSample), .wordTake(wordTake), .invCicBypass(invCicBypass));
	qud_bb_source qud_bb_source_inst (.clk(clk), .sys_rst(sys_rst), .wordTake(wordTake), .dataWord(dataWord));
	task automatic finalReport();
		$display("comparisons %0d mismatches %0d", testsRun, nMismatch);
		if (nMismatch == 0 && testsRun > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finalReport
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp) begin
			nMismatch++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : check
	// Byte write, strobe for exactly one edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regWrEn   <= 1'b1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge clk);
		regWrEn <= 1'b0;
	endtask : wr
	// Read data is registered one cycle after the address is seen
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		regAddr <= a;
		repeat (2) @(posedge clk);
		#1 check({24'h0, regRdData}, {24'h0, e});
	endtask : rd
	// Cycles to the next take pulse; a lost pulse ends the run
	task automatic nextTake(output int c);
		c = 0;
		do begin
			@(posedge clk);
			#1 c++;
		end while (wordTake !== 1'b1 && c < 400);
		if (c >= 400) begin
			nMismatch++;
			finalReport();
		end
	endtask : nextTake
	// First takes after a rate change are skipped, the slot phase may still settle
	task automatic expectGap(input int e);
		int c;
		repeat (3) nextTake(c);
		check(c, e);
		nextTake(c);
		check(c, e);
	endtask : expectGap
	initial begin
		{sys_rst, txEnable, profilePickLo, profilePickHi, tuningLoadStrobe, regWrEn} = 6'h20;
		regAddr = 8'h00;
		regWrData = 8'h00;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		#1 check({17'h0, wordTake, dacSample}, 32'h0);
		rd(8'h0C, 8'(`QUD_RST_RATE));
		for (int k = 0; k < 4; k++) wr(8'h08 + 8'(k), STEP[8*k +: 8]);
		for (int k = 0; k < 4; k++) rd(8'h08 + 8'(k), STEP[8*k +: 8]);
		wr(8'hF0, 8'hFF);
		rd(8'hF0, 8'h00);
		// With transmit off no word may be taken
		n = 0;
		repeat (60) begin
			@(posedge clk);
			#1 n += (wordTake === 1'b1);
		end
		check(n, 0);
		txEnable <= 1'b1;
		// Bypass, code 1 read as 2, a middle and the top rate
		for (int k = 0; k < 4; k++) begin
			wr(8'h0C, RATES[k]);
			expectGap(GAPS[k]);
			check(32'(invCicBypass), 32'(RATES[k][6]));
		end
		wr(8'h14, 8'h03);
		profilePickLo <= 1'b1;
		expectGap(6);
		txEnable <= 1'b0;
		profilePickLo <= 1'b0;
		for (int k = 0; k < 4; k++) wr(8'h08 + 8'(k), QTR[8*k +: 8]);
		wr(`QUD_ADDR_MODE, 8'h01);
		tuningLoadStrobe <= 1'b1;
		rd(`QUD_ADDR_MODE, 8'h01);
		repeat (30) @(posedge clk);
		for (int k = 0; k < 5; k++) begin
			@(posedge clk);
			#1 smp[k] = dacSample;
		end
		// Quarter turn per clock: half a period apart the carrier is negated
		s0 = smp[0] + smp[2];
		s1 = smp[0] - smp[2];
		check(32'(s0 inside {[-2:2]}), 1);
		check(32'(smp[4]), 32'(smp[0]));
		check(32'(!(s1 inside {[-1000:1000]}) || !((smp[1] - smp[3]) inside {[-1000:1000]})), 1);
		// Zero step on profile one: reload gives a DC level to compare sinc off and on
		tuningLoadStrobe <= 1'b0;
		profilePickLo <= 1'b1;
		repeat (10) @(posedge clk);
		tuningLoadStrobe <= 1'b1;
		rd(`QUD_ADDR_STATUS, 8'h08);
		repeat (30) @(posedge clk);
		#1 dcOff = dacSample;
		wr(8'h15, 8'h01);
		repeat (30) @(posedge clk);
		#1 dcOn = dacSample;
		check(32'((dcOn * 1000) inside {[dcOff * 640 : dcOff * 700]}), 1);
		// Quadrature mode, profile two: quarter-turn carrier from phase zero; a bypass pulse clears the CIC
		@(posedge clk);
		profilePickLo <= 1'b0;
		profilePickHi <= 1'b1;
		for (int k = 0; k < 4; k++) wr(8'h18 + 8'(k), QTR[8*k +: 8]);
		wr(8'h1C, 8'h40);
		wr(8'h1C, 8'h02);
		wr(`QUD_ADDR_MODE, 8'h00);
		txEnable <= 1'b1;
		repeat (300) @(posedge clk);
		// Second set taken 36 clocks later, same carrier phase, with the invert bit set
		for (int k = 0; k < 8; k++) begin
			if (k == 4) begin
				wr(8'h1C, 8'h82);
				repeat (30) @(posedge clk);
			end
			@(posedge clk);
			#1 smp[k] = dacSample;
		end
		// Word 0x0800 times carrier peak, shifted down by the product scaling: half of the word
		for (int k = 0; k < 8; k++) check(32'((smp[k] == 14'sh0400) || (smp[k] == -14'sh0400)), 1);
		check(32'((smp[4] != smp[0]) == (smp[6] != smp[2])), 1);
		check(32'((smp[5] != smp[1]) == (smp[7] != smp[3])), 1);
		check(32'((smp[4] != smp[0]) != (smp[5] != smp[1])), 1);
		finalReport();
	end
endmodule : qud_upconvert_tb
`default_nettype wire
